// File: src/pdc_cfg.svh
// constants for the projector direct command decoder
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_OFF_ADDR 4'h0
`define PDC_OFF_SET 4'h4
`define PDC_OFF_STAT 4'h8
`define PDC_SET_AUTOSHUT 0
`define PDC_SET_AFOCUS 1
`define PDC_SET_HILITE 2
`define PDC_SET_KEYLOCK 3
`define PDC_SET_FLOCK 4
`define PDC_SET_STANDBY 5
`define PDC_ST_LAMPSEL 4
`define PDC_ST_SHUTTER 5
`define PDC_ST_BUSY 6
`define PDC_ST_LAMPON 7
`define PDC_ST_FAN 8
`define PDC_RST_ADDR 5'h00
`define PDC_RST_SET 6'h01
`define PDC_MODE_SETRST 2'h1
`define PDC_MODE_DIRECT 2'h2
`define PDC_MODE_STATUS 2'h3
`define PDC_D_SLIDE_FWD 6'h00
`define PDC_D_SLIDE_BWD 6'h01
`define PDC_D_FOCUS_FWD 6'h02
`define PDC_D_FOCUS_BWD 6'h03
`define PDC_D_FOCUS_STOP 6'h04
`define PDC_D_SHUT_OPEN 6'h07
`define PDC_D_SHUT_CLOSE 6'h08
`define PDC_D_REINIT 6'h0b
`define PDC_D_LAMP_SWAP 6'h0c
`define PDC_D_CLR_FAULT 6'h0d
`define PDC_D_FADE_FREEZE 6'h0f
`define PDC_S_AFOCUS 6'h00
`define PDC_S_HILITE 6'h01
`define PDC_S_FLOCK 6'h02
`define PDC_S_AUTOSHUT 6'h03
`define PDC_S_KEYLOCK 6'h05
`define PDC_S_STANDBY 6'h07
`endif

// File: src/pdc_decoder.sv
// direct and set/reset command decoder of the slide projector
//
// Functional notes
// - focus lock stops motor, ignores all focus
// - focus lock off lets focus run again
// - standby turns lamp and fan off
// - standby accepts only the listed commands
// - leaving standby relights lamp, restores brightness
// - standby straight after reset keeps lamp dark
// - direct command: address, mode 10, 1; three bytes
// - act only on frames with own address; user commands are passed on for any address
// - six-bit code in byte two picks action
// - unused bit of byte two is ignored
// - slide commands run one transport cycle
// - focus runs until focus stop arrives
// - auto shutter opens after transport, needs slide
// - shutter close always closes the shutter
// - reinit runs init cycle, restores defaults
// - lamp swap toggles lamp unless lamp failed
// - clear fault resets error bits zero to three
// - fade freeze only acts while fading
// - user command: byte two msb 1, byte three zero
// - set bit turns focus lock, standby on/off
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_cfg.svh"
module pdc_decoder (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic [3:0] comm_err,
  input wire logic gate_pin,
  input wire logic xport_done_pin,
  input wire logic lamp_fail_pin,
  input wire logic fade_busy_pin,
  input wire logic key_fwd_pin,
  input wire logic key_bwd_pin,
  output logic xport_go,
  output logic xport_back,
  output logic focus_fwd,
  output logic focus_bwd,
  output logic shutter_open,
  output logic lamp_on,
  output logic fan_on,
  output logic lamp_sel,
  output logic bright_restore,
  output logic fade_freeze,
  output logic reinit_go,
  output logic user_valid,
  output logic [4:0] user_dev,
  output logic [6:0] user_code
);
  pdc_pkg::pdc_rx_state_t rx_st_q;
  pdc_pkg::pdc_frame_t fr_q;
  pdc_pkg::pdc_pins_t pin_raw, pin_m_q, pin_s_q;
  logic exec_q;
  logic [4:0] own_addr_q;
  logic [5:0] set_q;
  logic [3:0] err_q;
  logic busy_q, pend_q, done_prev_q, fresh_q, dark_q;
  logic hfwd_q, hbwd_q;
  logic [31:0] rdata_q;
  logic xport_go_q, xport_back_q, ffwd_q, fbwd_q, shut_q;
  logic lamp_on_q, fan_q, lamp_sel_q, bright_q, freeze_q, reinit_q;
  logic user_valid_q;
  logic [4:0] user_dev_q;
  logic [6:0] user_code_q;

  // which frames may run while the lamp is in standby
  function automatic logic standby_ok(input logic [1:0] mode,
                                      input logic [7:0] b2);
    logic [5:0] c;
    c = b2[7:2];
    case (mode)
      `PDC_MODE_STATUS: standby_ok = 1'b1;
      `PDC_MODE_DIRECT: standby_ok = !b2[7] && (c == `PDC_D_REINIT ||
        c == `PDC_D_LAMP_SWAP || c == `PDC_D_CLR_FAULT);
      `PDC_MODE_SETRST: standby_ok = c == `PDC_S_STANDBY ||
        c == `PDC_S_AUTOSHUT || c == `PDC_S_HILITE ||
        c == `PDC_S_AFOCUS || c == `PDC_S_KEYLOCK;
      default: standby_ok = 1'b0;
    endcase
  endfunction

  // one decoded command of a given mode and code
  function automatic logic is_cmd(input pdc_pkg::pdc_frame_t f,
                                  input logic [1:0] mode,
                                  input logic [5:0] code);
    is_cmd = f.b1[2:1] == mode && f.b2[7:2] == code &&
      !(mode == `PDC_MODE_DIRECT && f.b2[7]);
  endfunction

  assign pin_raw = '{key_bwd: key_bwd_pin, key_fwd: key_fwd_pin,
    fade_busy: fade_busy_pin, lamp_fail: lamp_fail_pin,
    xport_done: xport_done_pin, gate: gate_pin};

  // pins are asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
    end
  end

  // byte assembly; a first byte always has its low bit set
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rx_st_q <= pdc_pkg::PDC_WAIT1;
      fr_q <= '0;
      exec_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (rx_valid) begin
        case (rx_st_q)
          pdc_pkg::PDC_WAIT1: begin
            if (rx_data[0]) begin
              fr_q.b1 <= rx_data;
              rx_st_q <= pdc_pkg::PDC_WAIT2;
            end
          end
          pdc_pkg::PDC_WAIT2: begin
            fr_q.b2 <= rx_data;
            rx_st_q <= pdc_pkg::PDC_WAIT3;
          end
          pdc_pkg::PDC_WAIT3: begin
            fr_q.b3 <= rx_data;
            exec_q <= 1'b1;
            rx_st_q <= pdc_pkg::PDC_WAIT1;
          end
          default: rx_st_q <= pdc_pkg::PDC_WAIT1;
        endcase
      end
    end
  end

  logic mine, go, dir_ok, usr;
  logic c_sfwd, c_sbwd, c_ffwd, c_fbwd, c_fstop, c_open, c_close;
  logic c_reinit, c_swap, c_clr, c_freeze, c_stby, c_flock;
  logic done_rise, stby_on, stby_off, acted;
  assign mine = fr_q.b1[7:3] == own_addr_q;
  // b2[1] never enters direct decode
  assign go = exec_q && mine &&
    (!set_q[`PDC_SET_STANDBY] || standby_ok(fr_q.b1[2:1], fr_q.b2));
  assign dir_ok = go && !fr_q.b2[0];
  assign usr = exec_q && fr_q.b1[2:1] == `PDC_MODE_DIRECT &&
    fr_q.b2[7] && fr_q.b3 == 8'h00;
  assign c_sfwd = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_SLIDE_FWD);
  assign c_sbwd = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_SLIDE_BWD);
  assign c_ffwd = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_FOCUS_FWD);
  assign c_fbwd = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_FOCUS_BWD);
  assign c_fstop = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_FOCUS_STOP);
  assign c_open = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_SHUT_OPEN);
  assign c_close = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_SHUT_CLOSE);
  assign c_reinit = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_REINIT);
  assign c_swap = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_LAMP_SWAP);
  assign c_clr = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_CLR_FAULT);
  assign c_freeze = dir_ok && is_cmd(fr_q, `PDC_MODE_DIRECT, `PDC_D_FADE_FREEZE);
  assign c_stby = go && is_cmd(fr_q, `PDC_MODE_SETRST, `PDC_S_STANDBY);
  assign c_flock = go && is_cmd(fr_q, `PDC_MODE_SETRST, `PDC_S_FLOCK);
  assign stby_on = c_stby && fr_q.b2[1];
  assign stby_off = c_stby && !fr_q.b2[1] && set_q[`PDC_SET_STANDBY];
  assign done_rise = pin_s_q.xport_done && !done_prev_q;
  // an ignored direct code must not end the after-reset window either
  assign acted = c_sfwd || c_sbwd || c_ffwd || c_fbwd || c_fstop || c_open || c_close ||
    c_swap || c_clr || c_freeze || (go && fr_q.b1[2:1] != `PDC_MODE_DIRECT);

  // settings: set/reset commands and bus writes; standby is read-only on the bus
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      own_addr_q <= `PDC_RST_ADDR;
      set_q <= `PDC_RST_SET;
    end else begin
      if (reg_wr && reg_addr == `PDC_OFF_ADDR) begin
        own_addr_q <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `PDC_OFF_SET) begin
        set_q[4:0] <= reg_wdata[4:0];
      end
      if (c_reinit) begin
        set_q <= `PDC_RST_SET;
      end else if (go && fr_q.b1[2:1] == `PDC_MODE_SETRST) begin
        case (fr_q.b2[7:2])
          `PDC_S_AUTOSHUT: set_q[`PDC_SET_AUTOSHUT] <= fr_q.b2[1];
          `PDC_S_AFOCUS: set_q[`PDC_SET_AFOCUS] <= fr_q.b2[1];
          `PDC_S_HILITE: set_q[`PDC_SET_HILITE] <= fr_q.b2[1];
          `PDC_S_KEYLOCK: set_q[`PDC_SET_KEYLOCK] <= fr_q.b2[1];
          `PDC_S_FLOCK: set_q[`PDC_SET_FLOCK] <= fr_q.b2[1];
          `PDC_S_STANDBY: set_q[`PDC_SET_STANDBY] <= fr_q.b2[1];
          default: set_q <= set_q;
        endcase
      end
    end
  end

  // transport: a slide command while busy is dropped
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_prev_q <= 1'b0;
      xport_go_q <= 1'b0;
      xport_back_q <= 1'b0;
    end else begin
      done_prev_q <= pin_s_q.xport_done;
      xport_go_q <= 1'b0;
      if ((c_sfwd || c_sbwd) && !busy_q) begin
        xport_go_q <= 1'b1;
        xport_back_q <= c_sbwd;
        busy_q <= 1'b1;
      end else if (done_rise || c_reinit) begin
        busy_q <= 1'b0;
      end
    end
  end

  // focus motor: host run state plus live keypad, both gated by the lock
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hfwd_q <= 1'b0;
      hbwd_q <= 1'b0;
      ffwd_q <= 1'b0;
      fbwd_q <= 1'b0;
    end else begin
      if (set_q[`PDC_SET_FLOCK] || c_fstop || c_reinit || c_flock) begin
        hfwd_q <= 1'b0;
        hbwd_q <= 1'b0;
      end else if (c_ffwd) begin
        hfwd_q <= 1'b1;
        hbwd_q <= 1'b0;
      end else if (c_fbwd) begin
        hfwd_q <= 1'b0;
        hbwd_q <= 1'b1;
      end
      // both keys held cancel out rather than fight the motor
      ffwd_q <= !set_q[`PDC_SET_FLOCK] && (hfwd_q || pin_s_q.key_fwd) &&
        !(hbwd_q || pin_s_q.key_bwd);
      fbwd_q <= !set_q[`PDC_SET_FLOCK] && (hbwd_q || pin_s_q.key_bwd) &&
        !(hfwd_q || pin_s_q.key_fwd);
    end
  end

  // shutter: with auto shutter the transport owns it until the cycle ends
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      shut_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (c_close || c_reinit) begin
        shut_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (c_open && !set_q[`PDC_SET_AUTOSHUT]) begin
        shut_q <= 1'b1;
      end else if (c_open && !busy_q) begin
        shut_q <= pin_s_q.gate;
      end else if (c_open) begin
        pend_q <= 1'b1;
      end else if ((c_sfwd || c_sbwd) && !busy_q &&
                   set_q[`PDC_SET_AUTOSHUT]) begin
        shut_q <= 1'b0;
        pend_q <= 1'b1;
      end else if (done_rise && pend_q) begin
        shut_q <= pin_s_q.gate;
        pend_q <= 1'b0;
      end
    end
  end

  // lamp, fan and standby; brightness itself is held outside
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lamp_on_q <= 1'b1;
      fan_q <= 1'b1;
      lamp_sel_q <= 1'b0;
      bright_q <= 1'b0;
      fresh_q <= 1'b1;
      dark_q <= 1'b0;
    end else begin
      bright_q <= 1'b0;
      if (c_reinit) begin
        fresh_q <= 1'b1;
        lamp_on_q <= 1'b1;
        fan_q <= 1'b1;
        dark_q <= 1'b0;
      end else if (stby_on) begin
        lamp_on_q <= 1'b0;
        fan_q <= 1'b0;
        dark_q <= fresh_q;
      end else if (stby_off) begin
        lamp_on_q <= !dark_q;
        fan_q <= 1'b1;
        bright_q <= !dark_q;
        fresh_q <= 1'b0;
      end else if (acted) begin
        fresh_q <= 1'b0;
      end
      if (c_swap && !pin_s_q.lamp_fail) begin
        lamp_sel_q <= !lamp_sel_q;
      end
    end
  end

  // fault bits: a new fault in the clearing cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_err
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          err_q[gi] <= 1'b0;
        end else if (comm_err[gi]) begin
          err_q[gi] <= 1'b1;
        end else if (c_clr) begin
          err_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // one-cycle strobes toward the fade ramp, init sequencer and aux devices
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      freeze_q <= 1'b0;
      reinit_q <= 1'b0;
      user_valid_q <= 1'b0;
      user_dev_q <= 5'h00;
      user_code_q <= 7'h00;
    end else begin
      freeze_q <= c_freeze && pin_s_q.fade_busy;
      reinit_q <= c_reinit;
      user_valid_q <= usr;
      if (usr) begin
        user_dev_q <= fr_q.b1[7:3];
        user_code_q <= fr_q.b2[6:0];
      end
    end
  end

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `PDC_OFF_ADDR: rdata_q <= {27'h0, own_addr_q};
          `PDC_OFF_SET: rdata_q <= {26'h0, set_q};
          `PDC_OFF_STAT: rdata_q <= {23'h0, fan_q, lamp_on_q, busy_q,
            shut_q, lamp_sel_q, err_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign xport_go = xport_go_q;
  assign xport_back = xport_back_q;
  assign focus_fwd = ffwd_q;
  assign focus_bwd = fbwd_q;
  assign shutter_open = shut_q;
  assign lamp_on = lamp_on_q;
  assign fan_on = fan_q;
  assign lamp_sel = lamp_sel_q;
  assign bright_restore = bright_q;
  assign fade_freeze = freeze_q;
  assign reinit_go = reinit_q;
  assign user_valid = user_valid_q;
  assign user_dev = user_dev_q;
  assign user_code = user_code_q;

  lock_stop_a: assert property (@(posedge mclk) disable iff (!nrst)
    set_q[`PDC_SET_FLOCK] |=> !ffwd_q && !fbwd_q)
    else $error("focus motor runs under focus lock");
  standby_dark_a: assert property (@(posedge mclk) disable iff (!nrst)
    set_q[`PDC_SET_STANDBY] |-> !lamp_on_q && !fan_q)
    else $error("lamp or fan on in standby");
  standby_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    exec_q && set_q[`PDC_SET_STANDBY] && fr_q.b1[2:1] == `PDC_MODE_DIRECT &&
    !fr_q.b2[7] && fr_q.b2[7:2] <= `PDC_D_SHUT_CLOSE |=> !xport_go_q && $stable(shut_q))
    else $error("blocked command ran in standby");
  wake_lamp_a: assert property (@(posedge mclk) disable iff (!nrst)
    stby_off && !dark_q |=> lamp_on_q && fan_q && bright_q ##1 !bright_q)
    else $error("standby exit did not relight");
  fresh_dark_a: assert property (@(posedge mclk) disable iff (!nrst)
    stby_off && dark_q |=> !lamp_on_q && !bright_q)
    else $error("lamp lit after standby following reset");
  addr_filter_a: assert property (@(posedge mclk) disable iff (!nrst)
    exec_q && !mine |=> !xport_go_q && !reinit_q && !freeze_q)
    else $error("foreign address acted on");
  xport_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    xport_go_q |-> busy_q ##1 !xport_go_q)
    else $error("transport start not a single pulse");
  shut_close_a: assert property (@(posedge mclk) disable iff (!nrst)
    c_close |=> !shut_q)
    else $error("shutter not closed");
  swap_fail_a: assert property (@(posedge mclk) disable iff (!nrst)
    c_swap && pin_s_q.lamp_fail |=> lamp_sel_q == $past(lamp_sel_q))
    else $error("lamp swapped after failure");
  fault_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
    c_clr && comm_err == 4'h0 |=> err_q == 4'h0)
    else $error("fault bits not cleared");
  freeze_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    freeze_q |-> $past(pin_s_q.fade_busy, 1))
    else $error("freeze sent with no fade");
endmodule
`default_nettype wire

// File: src/pdc_pkg.sv
// types shared by the projector direct command decoder
package pdc_pkg;
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } pdc_frame_t;
  typedef enum logic [1:0] {
    PDC_WAIT1 = 2'h0,
    PDC_WAIT2 = 2'h1,
    PDC_WAIT3 = 2'h3
  } pdc_rx_state_t;
  typedef struct packed {
    logic key_bwd;
    logic key_fwd;
    logic fade_busy;
    logic lamp_fail;
    logic xport_done;
    logic gate;
  } pdc_pins_t;
endpackage

// File: verification/pdc_host_model.sv
// serial host model that hands command bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module pdc_host_model (
  input wire logic mclk,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end

  // gap 0 sends bytes back to back; idle data is the inverse of the last byte
  task automatic send(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
                      input int gap);
    logic [7:0] b [3];
    b = '{b1, b2, b3};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= b[i];
      if (gap > 0) begin
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_data <= ~b[i];
        repeat (gap - 1) @(posedge mclk);
      end
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~b[2];
  endtask
endmodule
`default_nettype wire

// File: verification/projector_direct_command_decoder_tb.sv
// self-checking bench of the projector direct command decoder
`timescale 1ns/1ps
`default_nettype none
`include "pdc_cfg.svh"
module projector_direct_command_decoder_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [3:0] comm_err = 4'h0;
  pdc_pkg::pdc_pins_t pins = '0;
  logic xport_go, xport_back, focus_fwd, focus_bwd, shutter_open, lamp_on, fan_on, lamp_sel;
  logic bright_restore, fade_freeze, reinit_go, user_valid;
  logic [4:0] user_dev, ud, own;
  logic [6:0] user_code, uc, snap;
  logic [4:0] seen = 5'h00;
  logic clr = 1'b0;
  logic exp_sel = 1'b0;
  logic [31:0] v;
  logic [5:0] undef [5] = '{6'h05, 6'h06, 6'h09, 6'h0a, 6'h0e};
  int miscompares = 0;
  int num_checks = 0;

  always #12.5 mclk = ~mclk;
  // pulses last one cycle, so they are latched until the next frame
  always @(posedge mclk)
    seen <= clr ? 5'h00 : seen | {user_valid, reinit_go, fade_freeze, bright_restore, xport_go};

  pdc_decoder pdc_decoder_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_data(rx_data), .rx_valid(rx_valid), .comm_err(comm_err), .gate_pin(pins.gate),
    .xport_done_pin(pins.xport_done), .lamp_fail_pin(pins.lamp_fail),
    .fade_busy_pin(pins.fade_busy), .key_fwd_pin(pins.key_fwd), .key_bwd_pin(pins.key_bwd),
    .xport_go(xport_go), .xport_back(xport_back), .focus_fwd(focus_fwd),
    .focus_bwd(focus_bwd), .shutter_open(shutter_open), .lamp_on(lamp_on), .fan_on(fan_on),
    .lamp_sel(lamp_sel), .bright_restore(bright_restore), .fade_freeze(fade_freeze),
    .reinit_go(reinit_go), .user_valid(user_valid), .user_dev(user_dev),
    .user_code(user_code));

  pdc_host_model pdc_host_model_inst (.mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid));

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // pins pass a two-flop synchroniser, so give them time to land
  task automatic setp(input int idx, input logic val);
    @(posedge mclk);
    pins[idx] <= val;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic done();
    setp(1, 1'b1);
    setp(1, 1'b0);
  endtask

  task automatic frame(input logic [4:0] a, input logic [1:0] m, input logic [7:0] b2);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    pdc_host_model_inst.send({a, m, 1'b1}, b2, 8'h00, $urandom_range(2, 0));
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // unused bit of byte two is random on every frame sent by dcmd
  task automatic dcmd(input logic [5:0] c);
    frame(own, `PDC_MODE_DIRECT, {c, 1'($urandom), 1'b0});
  endtask

  task automatic scmd(input logic [5:0] c, input logic s);
    frame(own, `PDC_MODE_SETRST, {c, s, 1'b0});
  endtask

  initial begin
    void'($urandom(8137));
    own = 5'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    #1 chk({lamp_on, fan_on, lamp_sel, shutter_open}, 4'hc);
    rd(4'h4);
    chk(v, 32'h1);
    rd(4'hc);
    chk(v, 32'h0);
    scmd(`PDC_S_STANDBY, 1'b1);
    chk({lamp_on, fan_on}, 2'b00);
    rd(4'h4);
    chk(v, 32'h21);
    scmd(`PDC_S_STANDBY, 1'b0);
    chk({lamp_on, fan_on}, 2'b01);
    wr(4'h4, 32'h1e);
    rd(4'h4);
    chk(v, 32'h1e);
    dcmd(`PDC_D_REINIT);
    rd(4'h4);
    chk(v, 32'h1);
    chk(seen[3], 1'b1);
    own = 5'($urandom_range(31, 1));
    wr(4'h0, {27'h0, own});
    wr(4'h4, 32'h0);
    frame(own ^ 5'h01, `PDC_MODE_DIRECT, {`PDC_D_SHUT_OPEN, 2'b00});
    chk(shutter_open, 1'b0);
    frame(own, `PDC_MODE_DIRECT, {`PDC_D_SHUT_OPEN, 2'b01});
    chk(shutter_open, 1'b0);
    dcmd(`PDC_D_SHUT_OPEN);
    chk(shutter_open, 1'b1);
    dcmd(`PDC_D_SHUT_CLOSE);
    chk(shutter_open, 1'b0);
    dcmd(`PDC_D_FOCUS_FWD);
    chk({focus_fwd, focus_bwd}, 2'b10);
    dcmd(`PDC_D_FOCUS_BWD);
    chk({focus_fwd, focus_bwd}, 2'b01);
    scmd(`PDC_S_FLOCK, 1'b1);
    chk({focus_fwd, focus_bwd}, 2'b00);
    dcmd(`PDC_D_FOCUS_FWD);
    setp(4, 1'b1);
    chk({focus_fwd, focus_bwd}, 2'b00);
    setp(4, 1'b0);
    scmd(`PDC_S_FLOCK, 1'b0);
    dcmd(`PDC_D_FOCUS_FWD);
    chk({focus_fwd, focus_bwd}, 2'b10);
    dcmd(`PDC_D_FOCUS_STOP);
    chk({focus_fwd, focus_bwd}, 2'b00);
    dcmd(`PDC_D_SLIDE_FWD);
    chk({seen[0], xport_back}, 2'b10);
    done();
    dcmd(`PDC_D_SLIDE_BWD);
    chk({seen[0], xport_back}, 2'b11);
    done();
    wr(4'h4, 32'h1);
    for (int g = 1; g >= 0; g--) begin
      setp(0, g[0]);
      dcmd(`PDC_D_SLIDE_FWD);
      dcmd(`PDC_D_SHUT_OPEN);
      chk(shutter_open, 1'b0);
      done();
      chk(shutter_open, g[0]);
    end
    for (int f = 0; f < 4; f++) begin
      if (f == 2) setp(2, 1'b1);
      dcmd(`PDC_D_LAMP_SWAP);
      if (f < 2) exp_sel = ~exp_sel;
      chk(lamp_sel, exp_sel);
    end
    setp(2, 1'b0);
    v = $urandom_range(15, 1);
    @(posedge mclk);
    comm_err <= v[3:0];
    snap = {3'h0, v[3:0]};
    @(posedge mclk);
    comm_err <= 4'h0;
    rd(4'h8);
    chk(v[3:0], snap[3:0]);
    dcmd(`PDC_D_CLR_FAULT);
    rd(4'h8);
    chk(v[3:0], 4'h0);
    for (int b = 0; b < 2; b++) begin
      setp(3, b[0]);
      dcmd(`PDC_D_FADE_FREEZE);
      chk(seen[2], b[0]);
    end
    setp(3, 1'b0);
    scmd(`PDC_S_STANDBY, 1'b1);
    chk({lamp_on, fan_on}, 2'b00);
    dcmd(`PDC_D_FOCUS_FWD);
    chk({focus_fwd, focus_bwd}, 2'b00);
    scmd(`PDC_S_KEYLOCK, 1'b1);
    rd(4'h4);
    chk(v, 32'h29);
    dcmd(`PDC_D_LAMP_SWAP);
    exp_sel = ~exp_sel;
    chk(lamp_sel, exp_sel);
    scmd(`PDC_S_STANDBY, 1'b0);
    chk({lamp_on, fan_on, seen[1]}, 3'b111);
    repeat (4) begin
      ud = 5'($urandom);
      uc = 7'($urandom);
      frame(ud, `PDC_MODE_DIRECT, {1'b1, uc});
      chk({seen[4], user_dev, user_code}, {1'b1, ud, uc});
    end
    for (int i = 0; i < 8; i++) begin
      snap = {xport_back, focus_fwd, focus_bwd, shutter_open, lamp_on, fan_on, lamp_sel};
      dcmd(i < 5 ? undef[i] : 6'($urandom_range(31, 16)));
      chk({seen[3:0], xport_back, focus_fwd, focus_bwd, shutter_open, lamp_on, fan_on,
           lamp_sel}, {4'h0, snap});
    end
    end_of_test();
  end

  // the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
